// ---- hw/umpc_map.vh ----
// register map, field positions and reset values of the serial port mode block
`ifndef UMPC_MAP_VH
`define UMPC_MAP_VH

// ***************************************
// register byte addresses
// ***************************************
`define UMPC_ADDR_MODE      12'h000
`define UMPC_ADDR_STATUS    12'h004
`define UMPC_ADDR_MASK      12'h008
`define UMPC_ADDR_IDLE      12'h00C

// ***************************************
// mode register fields
// ***************************************
`define UMPC_PORT_ON        15
`define UMPC_IDLE_HALT      13
`define UMPC_IR_ON          12
`define UMPC_RTS_STYLE      11
`define UMPC_USAGE_HI       9
`define UMPC_USAGE_LO       8
`define UMPC_WAKE_ON        7
`define UMPC_LOOPBACK       6
`define UMPC_HS_BAUD        3
`define UMPC_MODE_WMASK     16'hBBFF
`define UMPC_MODE_RESET     16'h0000

// ***************************************
// pin usage encodings
// ***************************************
`define UMPC_USE_TXRX       2'b00
`define UMPC_USE_RTS        2'b01
`define UMPC_USE_ALL        2'b10
`define UMPC_USE_BCLK       2'b11

// ***************************************
// status and mask bits
// ***************************************
`define UMPC_EV_WAKE        0
`define UMPC_EV_W           2
`define UMPC_EV_RESET       2'b00

`endif

// ---- hw/umpc_sync3.v ----
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/100ps
module umpc_sync3 (
    // clock and reset
    input  wire mclk,
    input  wire rst,
    // pin in, filtered level out
    input  wire pin_in,
    output reg  level
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge mclk) begin
        if (rst) begin
            s1    <= 1'b1;
            s2    <= 1'b1;
            s3    <= 1'b1;
            level <= 1'b1;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

// ---- hw/umpc_top.v ----
// mode and pin control of an asynchronous serial port, apb slave
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "umpc_map.vh"
module umpc_top (
    // clock and reset
    input  wire        mclk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // device power state
    input  wire        dev_idle,
    input  wire        dev_sleep,
    // core serial datapath
    input  wire        core_tx,
    input  wire        core_rts,
    input  wire        core_bclk,
    output reg         core_rx,
    output reg         core_cts,
    output reg         core_run,
    output reg         core_ir_mode,
    output reg         core_rts_simplex,
    // general-purpose latch values for the tx, rts and cts pins
    input  wire        latch_tx,
    input  wire        latch_rts,
    input  wire        latch_cts,
    // pins, output enable low while driven
    input  wire        serial_rx_pin,
    input  wire        clear_to_send_pin,
    output reg         serial_tx_pin,
    output reg         serial_tx_pin_oe_n,
    output reg         request_to_send_pin,
    output reg         request_to_send_pin_oe_n,
    // pin ownership, high where the port owns a pin
    output reg  [3:0]  pin_owned,
    // interrupt
    output reg         irq
);
    reg  [15:0] mode;
    reg  [1:0]  evt;
    reg  [1:0]  evt_mask;
    reg         wake_armed;
    reg         rx_prev;
    reg  [31:0] next_prdata;
    reg         ir_tx;
    reg         ir_rx;
    reg         tx_line;
    wire        rx_lvl;
    wire        cts_lvl;
    wire        port_on;
    wire        idle_halt_sel;
    wire        infrared_codec_on;
    wire        rts_pin_style;
    wire [1:0]  pin_usage_sel;
    wire        wake_on;
    wire        loopback_sel;
    wire        wr;
    wire        rd;
    wire        rx_fall;
    wire        rx_rise;
    wire        use_rts;
    wire        use_cts;
    wire        use_bclk;

    // ***************************************
    // pin synchronisers
    // ***************************************
    umpc_sync3 u_sync_rx (
        .mclk   (mclk),
        .rst    (rst),
        .pin_in (serial_rx_pin),
        .level  (rx_lvl)
    );
    umpc_sync3 u_sync_cts (
        .mclk   (mclk),
        .rst    (rst),
        .pin_in (clear_to_send_pin),
        .level  (cts_lvl)
    );

    assign port_on           = mode[`UMPC_PORT_ON];
    assign idle_halt_sel     = mode[`UMPC_IDLE_HALT];
    assign infrared_codec_on = mode[`UMPC_IR_ON];
    assign rts_pin_style     = mode[`UMPC_RTS_STYLE];
    assign pin_usage_sel     = mode[`UMPC_USAGE_HI:`UMPC_USAGE_LO];
    assign wake_on           = mode[`UMPC_WAKE_ON];
    assign loopback_sel      = mode[`UMPC_LOOPBACK];

    // ***************************************
    // apb access
    // ***************************************
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & penable & ~pwrite;
    assign rx_fall = rx_prev & ~rx_lvl;
    assign rx_rise = ~rx_prev & rx_lvl;

    always @* begin
        next_prdata = 32'h0000_0000;
        if (paddr == `UMPC_ADDR_MODE) begin
            next_prdata[15:0] = mode;
        end else if (paddr == `UMPC_ADDR_STATUS) begin
            next_prdata[`UMPC_EV_W-1:0] = evt;
        end else if (paddr == `UMPC_ADDR_MASK) begin
            next_prdata[`UMPC_EV_W-1:0] = evt_mask;
        end else if (paddr == `UMPC_ADDR_IDLE) begin
            next_prdata[0] = core_run;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ***************************************
    // mode register and wake logic
    // ***************************************
    always @(posedge mclk) begin
        if (rst) begin
            mode       <= `UMPC_MODE_RESET;
            wake_armed <= 1'b0;
            rx_prev    <= 1'b1;
        end else begin
            rx_prev <= rx_lvl;
            if (wr && paddr == `UMPC_ADDR_MODE) begin
                mode <= pwdata[15:0] & `UMPC_MODE_WMASK;
                wake_armed <= 1'b0;
            end else if (wake_on && port_on) begin
                if (rx_fall) begin
                    wake_armed <= 1'b1;
                end else if (wake_armed && rx_rise) begin
                    mode[`UMPC_WAKE_ON] <= 1'b0;
                    wake_armed <= 1'b0;
                end
            end
        end
    end

    // ***************************************
    // events and interrupt
    // ***************************************
    always @(posedge mclk) begin
        if (rst) begin
            evt      <= `UMPC_EV_RESET;
            evt_mask <= `UMPC_EV_RESET;
            irq      <= 1'b0;
        end else begin
            if (wr && paddr == `UMPC_ADDR_MASK) begin
                evt_mask <= pwdata[`UMPC_EV_W-1:0];
            end
            // a new event wins over the clear by read
            evt <= ((rd && paddr == `UMPC_ADDR_STATUS) ? `UMPC_EV_RESET : evt)
                   | {1'b0, wake_on & port_on & rx_fall};
            irq <= |(evt & evt_mask);
        end
    end

    // ***************************************
    // run state, codec and loopback
    // ***************************************
    assign use_rts  = pin_usage_sel == `UMPC_USE_RTS || pin_usage_sel == `UMPC_USE_ALL;
    assign use_cts  = pin_usage_sel == `UMPC_USE_ALL;
    assign use_bclk = pin_usage_sel == `UMPC_USE_BCLK;

    always @(posedge mclk) begin
        if (rst) begin
            core_run         <= 1'b0;
            core_ir_mode     <= 1'b0;
            core_rts_simplex <= 1'b0;
            ir_rx            <= 1'b1;
            core_rx          <= 1'b1;
            core_cts         <= 1'b0;
            ir_tx            <= 1'b0;
        end else begin
            core_run         <= port_on & ~(idle_halt_sel & dev_idle) & ~dev_sleep;
            core_ir_mode     <= infrared_codec_on;
            core_rts_simplex <= rts_pin_style;
            // decoder: low pulse on rx line means a zero bit
            ir_rx   <= infrared_codec_on ? ~rx_lvl : rx_lvl;
            core_rx <= loopback_sel ? core_tx : (infrared_codec_on ? ~ir_rx : rx_lvl);
            core_cts <= (use_cts && !loopback_sel) ? cts_lvl : 1'b0;
            // encoder: a zero bit becomes a high pulse, idle line low
            ir_tx   <= infrared_codec_on & ~core_tx;
        end
    end

    // ***************************************
    // pin multiplexing
    // ***************************************
    always @* begin
        tx_line = infrared_codec_on ? ir_tx : core_tx;
    end

    always @(posedge mclk) begin
        if (rst) begin
            serial_tx_pin            <= 1'b1;
            serial_tx_pin_oe_n       <= 1'b1;
            request_to_send_pin      <= 1'b1;
            request_to_send_pin_oe_n <= 1'b1;
            pin_owned                <= 4'h0;
        end else if (!port_on) begin
            serial_tx_pin            <= latch_tx;
            serial_tx_pin_oe_n       <= 1'b0;
            request_to_send_pin      <= latch_rts;
            request_to_send_pin_oe_n <= 1'b0;
            pin_owned                <= 4'h0;
        end else begin
            // loopback holds tx high on the pin
            serial_tx_pin            <= loopback_sel ? 1'b1 : tx_line;
            serial_tx_pin_oe_n       <= 1'b0;
            request_to_send_pin_oe_n <= 1'b0;
            if (use_rts) begin
                request_to_send_pin <= core_rts;
            end else if (use_bclk) begin
                request_to_send_pin <= core_bclk;
            end else begin
                request_to_send_pin <= latch_rts;
            end
            pin_owned <= {use_cts, use_rts | use_bclk, 2'b11};
        end
    end

endmodule

// ---- dv/umpc_assertions.sv ----
// checker of the serial port mode block ports
`timescale 1ns/100ps
module umpc_chk (
    // used ports of the block
    input wire        mclk, rst, psel, penable, pwrite, pready, pslverr, dev_idle, dev_sleep,
    input wire        core_tx, core_rts, core_bclk, core_run, core_ir_mode, latch_tx, latch_rts,
    input wire        serial_rx_pin, serial_tx_pin, request_to_send_pin, irq,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [3:0]  pin_owned
);
    reg  [15:0] m;
    reg         msk, wk, wr_d, wr_d2, rst_d;
    wire        wr    = psel & penable & pwrite;
    wire        quiet = !wr_d & !rst_d;
    wire [1:0]  u     = m[9:8];
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ***************
    // shadow of mode and mask
    // ***************
    always @(posedge mclk) begin
        rst_d <= rst;
        wr_d  <= wr & paddr == 12'h000;
        wr_d2 <= wr_d;
        if (rst) begin
            m   <= 16'h0000;
            msk <= 1'b0;
            wk  <= 1'b0;
        end else begin
            if (wr & paddr == 12'h000) m <= pwdata[15:0];
            if (wr & paddr == 12'h008) msk <= pwdata[0];
            if (wr & paddr == 12'h000) wk <= pwdata[7];
            else if ($rose(serial_rx_pin)) wk <= 1'b0;
        end
    end
    // ***************
    // assertions
    // ***************
    a_apb_ready: assert property (psel |-> pready && !pslverr)
        else $error("slave stalled or flagged an error");
    a_unmapped_zero: assert property (psel && penable && !pwrite && paddr > 12'h00C |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_pin_owner: assert property (quiet |-> pin_owned == (!m[15] ? 4'h0 : {u == 2'b10, u != 2'b00, 2'b11}))
        else $error("pin ownership wrong");
    a_tx_source: assert property (quiet && !wr_d2 |-> serial_tx_pin == (!m[15] ? $past(latch_tx) : m[6] ? 1'b1 :
        m[12] ? !$past(core_tx, 2) : $past(core_tx))) else $error("tx pin source wrong");
    a_rts_source: assert property (quiet |-> request_to_send_pin == ((!m[15] || u == 2'b00) ? $past(latch_rts) :
        u == 2'b11 ? $past(core_bclk) : $past(core_rts))) else $error("rts pin source wrong");
    a_run_state: assert property (quiet |-> core_run == $past(m[15] & !(m[13] & dev_idle) & !dev_sleep)
        && core_ir_mode == m[12]) else $error("run or infrared state wrong");
    a_irq_masked: assert property (!msk && !$past(msk) |-> !irq)
        else $error("irq while masked");
    a_wake_irq: assert property (wk && m[15] && msk && $fell(serial_rx_pin) |-> ##[3:8] irq)
        else $error("no wake irq after rx fall");
endmodule
bind umpc_top umpc_chk i_chk (.*);

// ---- dv/umpc_far.sv ----
// far-side serial transceiver model
`timescale 1ns/100ps
module umpc_far (
    // link pins
    input  wire  mclk,
    input  wire  serial_tx_pin,
    output logic serial_rx_pin,
    output logic clear_to_send_pin
);
    initial begin
        serial_rx_pin = 1'b1;
        clear_to_send_pin = 1'b1;
    end
    // start bit: line low for len cycles, then back to idle mark
    task start_bit(input int len);
        @(posedge mclk);
        serial_rx_pin <= 1'b0;
        repeat (len) @(posedge mclk);
        serial_rx_pin <= 1'b1;
    endtask
endmodule

// ---- dv/umpc_top_tb_top.sv ----
// self-checking bench of the serial port mode block
`timescale 1ns/100ps
module umpc_top_tb_top;
    logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, dev_idle = 0, dev_sleep = 0;
    logic        core_tx = 0, core_rts = 0, core_bclk = 1, latch_tx = 1, latch_rts = 1, latch_cts = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, q;
    wire         pready, pslverr, core_rx, core_cts, core_run, core_ir_mode, core_rts_simplex, irq;
    wire         serial_tx_pin, serial_tx_pin_oe_n, request_to_send_pin, request_to_send_pin_oe_n;
    wire         serial_rx_pin, clear_to_send_pin;
    wire [31:0]  prdata;
    wire [3:0]   pin_owned;
    int          bad_count = 0, n_tests = 0, cyc = 0;
    umpc_top i_dut (.*);
    umpc_far i_far (.mclk, .serial_tx_pin, .serial_rx_pin, .clear_to_send_pin);
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    task results;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task settle;
        repeat (8) @(posedge mclk);
    endtask
    task t_regs;
        bus(0, 12'h000, 0); chk("mode", 0, q);
        chk("owned", 0, 32'(pin_owned));
        bus(1, 12'h000, 32'h0000_FFFF); bus(0, 12'h000, 0); chk("mode", 32'h0000_BBFF, q);
        bus(0, 12'h010, 0); chk("unmapped", 0, q);
        bus(1, 12'h000, 0); $display("regs test done");
    endtask
    task t_usage;
        for (int u = 0; u < 4; u++) begin
            bus(1, 12'h000, 32'h0000_8000 | u << 8); settle;
            chk("owned", {u == 2, u != 0, 2'b11}, 32'(pin_owned));
            chk("rts", u == 0 ? 1 : u == 3 ? 1 : 0, 32'(request_to_send_pin));
            chk("cts", u == 2, 32'(core_cts));
            chk("tx", 0, 32'(serial_tx_pin));
            chk("tx oe", 0, 32'(serial_tx_pin_oe_n));
            chk("rts oe", 0, 32'(request_to_send_pin_oe_n));
        end
        bus(1, 12'h000, 32'h0000_0300); settle;
        chk("owned", 0, 32'(pin_owned));
        chk("tx", 1, 32'(serial_tx_pin));
        $display("usage test done");
    endtask
    task t_modes;
        bus(1, 12'h000, 32'h0000_9000); settle;
        chk("ir", 1, 32'(core_ir_mode)); chk("tx", 1, 32'(serial_tx_pin));
        bus(1, 12'h000, 32'h0000_8840); settle;
        chk("tx", 1, 32'(serial_tx_pin)); chk("rx", 0, 32'(core_rx));
        chk("simplex", 1, 32'(core_rts_simplex));
        bus(1, 12'h000, 32'h0000_A000); dev_idle <= 1'b1; settle;
        chk("run", 0, 32'(core_run)); bus(0, 12'h00C, 0); chk("run reg", 0, q);
        bus(1, 12'h000, 32'h0000_8000); settle; chk("run", 1, 32'(core_run));
        dev_idle <= 1'b0; $display("modes test done");
    endtask
    task t_wake;
        bus(1, 12'h008, 1); dev_sleep <= 1'b1; bus(1, 12'h000, 32'h0000_8080);
        i_far.start_bit(10); settle; chk("irq", 1, 32'(irq));
        bus(0, 12'h000, 0); chk("wake bit", 32'h0000_8000, q);
        bus(0, 12'h004, 0); chk("status", 1, q); settle; chk("irq", 0, 32'(irq));
        bus(1, 12'h008, 0); bus(1, 12'h000, 32'h0000_8080); i_far.start_bit(10); settle;
        chk("irq", 0, 32'(irq)); bus(0, 12'h004, 0); chk("status", 1, q);
        dev_sleep <= 1'b0; bus(1, 12'h000, 0); $display("wake test done");
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        t_regs; t_usage; t_modes; t_wake;
        results();
    end
endmodule
